//--- urx_pkg.sv
/*
 package for the rx endpoint status/control block: register offsets,
 field positions, reset values, modes and carrier structs.
 assumes a 32-bit classic wishbone register bus.
*/
package urx_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFF_CSR = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_MODE = 4'hC;

   localparam int unsigned BIT_ERR = 18;
   localparam int unsigned BIT_FULL = 17;
   localparam int unsigned BIT_RDY = 16;
   localparam int unsigned PAYLOAD_REPEAT_COUNT_HI = 15;
   localparam int unsigned PAYLOAD_REPEAT_COUNT_LO = 11;
   localparam int unsigned MAXP_HI = 10;
   localparam int unsigned MAXP_LO = 0;
   localparam int unsigned MAXP_W = 11;
   localparam int unsigned PAYLOAD_REPEAT_COUNT_W = 5;
   localparam int unsigned PAY_W = 17;

   localparam logic [1:0] NODATA_TRIES = 2'h3;
   localparam logic [MAXP_W-1:0] MAXP_RST = 11'h000;
   localparam logic [PAYLOAD_REPEAT_COUNT_W-1:0] PAYLOAD_REPEAT_COUNT_RST = 5'h00;

   // interrupt status/mask layout
   localparam int unsigned IRQ_RDY = 0;
   localparam int unsigned IRQ_ERR = 1;
   localparam int unsigned IRQ_W = 2;

   // endpoint transfer type
   typedef enum logic [1:0] {
      URX_XFER_CTRL = 2'h0,
      URX_XFER_ISO = 2'h1,
      URX_XFER_BULK = 2'h2,
      URX_XFER_INT = 2'h3
   } urx_xfer_t;

   // events from the receive engine, one-cycle pulses
   typedef struct packed {
      logic pkt_done;
      logic pkt_dropped;
      logic rx_attempt_empty;
      logic rx_attempt_data;
   } urx_evt_t;

   typedef struct packed {
      logic [MAXP_W-1:0] limit;
      logic [PAYLOAD_REPEAT_COUNT_W-1:0] repeat_count;
      logic [PAY_W-1:0] payload_bytes;
   } urx_cfg_t;
endpackage : urx_pkg

//--- urx_flag.sv
/*
 one sticky flag: hardware set wins over software clear.
 assumes set and clear are single-cycle strobes on clk_sys.
*/
`timescale 1ns/1ps
module urx_flag
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic set,
   input wire logic clr,
   output logic flag
);
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         flag <= 1'b0;
      else if (set)
         flag <= 1'b1;
      else if (clr)
         flag <= 1'b0;
   end
endmodule : urx_flag

//--- urx_ctrl.sv
/*
 rx endpoint status and payload control with wishbone slave and interrupt.
 assumes a receive engine gives one-cycle event pulses and a fifo-full level,
 all synchronous to clk_sys.
*/
// Added by the designer: the register offsets and the Wishbone interface to the registers.
// Contract
// RL1 - in device mode a dropped OUT packet sets the overrun flag in bit 18.
// RL2 - the overrun flag reads zero when the endpoint is bulk.
// RL3 - in host mode three empty receive attempts set bit 18 and interrupt.
// RL4 - the host no-data flag reads zero for an isochronous endpoint.
// RL5 - bit 17 reads one while the fifo cannot take another packet.
// RL6 - a received packet sets bit 16 and raises an interrupt.
// RL7 - software clears bit 16 by writing zero after unloading the packet.
// RL8 - software clears bit 18 by writing zero; hardware never clears it.
// RL9 - payload size is the limit times the repeat count plus one.
// RL10 - for bulk the repeat count splits one fifo packet into bus packets.
// RL11 - software loads only bulk packets that are whole multiples of limit.
// RL12 - software sets repeat count 2 or 3 for high-speed iso or interrupt.
// RL13 - bits 10 to 0 hold the per-transaction payload limit in bytes.
// RL14 - in dma mode 1 software keeps the payload limit even.
// RL15 - bit 17 falls as soon as a packet is unloaded and a slot frees.
`timescale 1ns/1ps
module urx_ctrl
(
   input wire logic clk_sys,
   input wire logic reset,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [urx_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // receive engine side
   input wire logic host_mode,
   input wire urx_pkg::urx_xfer_t xfer_type,
   input wire logic fifo_no_room,
   input wire urx_pkg::urx_evt_t evt,
   output urx_pkg::urx_cfg_t cfg,
   output logic irq
);
   // --------------------------------------------------------------
   // bus decode
   // --------------------------------------------------------------
   logic req;
   logic wr;
   logic rd;
   logic sel_csr;
   logic sel_stat;
   logic sel_mask;
   logic sel_mode;
   logic [31:0] next_dat;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;
   assign rd = req && !wb_we_i;

   always_comb
   begin
      sel_csr = 1'b0;
      sel_stat = 1'b0;
      sel_mask = 1'b0;
      sel_mode = 1'b0;
      if (wb_adr_i == urx_pkg::OFF_CSR)
         sel_csr = 1'b1;
      else if (wb_adr_i == urx_pkg::OFF_IRQ_STAT)
         sel_stat = 1'b1;
      else if (wb_adr_i == urx_pkg::OFF_IRQ_MASK)
         sel_mask = 1'b1;
      else if (wb_adr_i == urx_pkg::OFF_MODE)
         sel_mode = 1'b1;
   end

   // --------------------------------------------------------------
   // configuration fields
   // --------------------------------------------------------------
   logic [urx_pkg::MAXP_W-1:0] limit;
   logic [urx_pkg::PAYLOAD_REPEAT_COUNT_W-1:0] repeat_count;
   logic dma_mode1;
   logic [urx_pkg::IRQ_W-1:0] mask;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         limit <= urx_pkg::MAXP_RST;
      else if (wr && sel_csr)
      begin
         if (wb_sel_i[0])
            limit[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1])
            limit[urx_pkg::MAXP_W-1:8] <= wb_dat_i[urx_pkg::MAXP_HI:8]; // [RL13]
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         repeat_count <= urx_pkg::PAYLOAD_REPEAT_COUNT_RST;
      else if (wr && sel_csr && wb_sel_i[1])
         repeat_count <= wb_dat_i[urx_pkg::PAYLOAD_REPEAT_COUNT_HI:urx_pkg::PAYLOAD_REPEAT_COUNT_LO];
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         mask <= '0;
         dma_mode1 <= 1'b0;
      end
      else
      begin
         if (wr && sel_mask && wb_sel_i[0])
            mask <= wb_dat_i[urx_pkg::IRQ_W-1:0];
         if (wr && sel_mode && wb_sel_i[0])
            dma_mode1 <= wb_dat_i[0];
      end
   end

   // payload = limit * (count + 1); a count of 31 gives the 32 split
   // packets a bulk endpoint may use
   logic [urx_pkg::PAY_W-1:0] payload;
   assign payload = urx_pkg::PAY_W'(limit) *
      urx_pkg::PAY_W'({1'b0, repeat_count} + 6'h01); // [RL9] [RL10]

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         cfg <= '0;
      else
      begin
         cfg.limit <= limit; // [RL13]
         cfg.repeat_count <= repeat_count; // [RL10]
         cfg.payload_bytes <= payload; // [RL9]
      end
   end

   // --------------------------------------------------------------
   // status flags
   // --------------------------------------------------------------
   logic is_iso;
   logic is_bulk;
   logic wr_csr_b2;
   logic set_rdy;
   logic set_err;
   logic clr_rdy;
   logic clr_err;
   logic rdy_flag;
   logic err_flag;
   logic err_visible;
   logic [1:0] empty_tries;

   assign is_iso = xfer_type == urx_pkg::URX_XFER_ISO;
   assign is_bulk = xfer_type == urx_pkg::URX_XFER_BULK;
   assign wr_csr_b2 = wr && sel_csr && wb_sel_i[2];
   // only a written zero clears; writing one has no effect
   assign clr_rdy = wr_csr_b2 && !wb_dat_i[urx_pkg::BIT_RDY]; // [RL7]
   assign clr_err = wr_csr_b2 && !wb_dat_i[urx_pkg::BIT_ERR]; // [RL8]

   // consecutive empty attempts in host mode; data resets the run
   always_ff @(posedge clk_sys)
   begin
      if (reset || !host_mode || evt.rx_attempt_data)
         empty_tries <= 2'h0;
      else if (evt.rx_attempt_empty)
      begin
         if (empty_tries == urx_pkg::NODATA_TRIES - 2'h1)
            empty_tries <= 2'h0;
         else
            empty_tries <= empty_tries + 2'h1;
      end
   end

   assign set_rdy = evt.pkt_done; // [RL6]
   assign set_err = host_mode
      ? (evt.rx_attempt_empty && !evt.rx_attempt_data
         && empty_tries == urx_pkg::NODATA_TRIES - 2'h1) // [RL3]
      : evt.pkt_dropped; // [RL1]

   urx_flag u_rdy
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .set(set_rdy),
      .clr(clr_rdy),
      .flag(rdy_flag)
   );

   urx_flag u_err
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .set(set_err),
      .clr(clr_err),
      .flag(err_flag)
   );

   // flag reads zero in the transfer type where it has no meaning
   assign err_visible = err_flag &&
      (host_mode ? !is_iso : !is_bulk); // [RL2] [RL4]

   // --------------------------------------------------------------
   // interrupt status, cleared by reading it
   // --------------------------------------------------------------
   logic [urx_pkg::IRQ_W-1:0] istat;
   logic [urx_pkg::IRQ_W-1:0] ievt;
   logic rd_stat;

   assign ievt[urx_pkg::IRQ_RDY] = set_rdy; // [RL6]
   assign ievt[urx_pkg::IRQ_ERR] = set_err && host_mode && !is_iso; // [RL3]
   assign rd_stat = rd && sel_stat;

   // a new event in the read cycle survives the clear
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         istat <= '0;
      else if (rd_stat)
         istat <= ievt;
      else
         istat <= istat | ievt;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |((rd_stat ? ievt : (istat | ievt)) & mask);
   end

   // --------------------------------------------------------------
   // read data and acknowledge
   // --------------------------------------------------------------
   always_comb
   begin
      next_dat = 32'h0000_0000;
      if (sel_csr)
      begin
         next_dat[urx_pkg::MAXP_HI:urx_pkg::MAXP_LO] = limit;
         next_dat[urx_pkg::PAYLOAD_REPEAT_COUNT_HI:urx_pkg::PAYLOAD_REPEAT_COUNT_LO] = repeat_count;
         next_dat[urx_pkg::BIT_RDY] = rdy_flag;
         next_dat[urx_pkg::BIT_FULL] = fifo_no_room; // [RL5] [RL15]
         next_dat[urx_pkg::BIT_ERR] = err_visible;
      end
      else if (sel_stat)
         next_dat[urx_pkg::IRQ_W-1:0] = istat;
      else if (sel_mask)
         next_dat[urx_pkg::IRQ_W-1:0] = mask;
      else if (sel_mode)
         next_dat[0] = dma_mode1;
   end

   // unmapped addresses ack with zero data and ignore writes
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= req;
         if (rd)
            wb_dat_o <= next_dat;
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   bulk_overrun_zero_a: assert property (@(posedge clk_sys) // [RL2]
      disable iff (reset)
      (!host_mode && is_bulk && rd && sel_csr)
      |=> !wb_dat_o[urx_pkg::BIT_ERR])
      else $error("overrun bit read nonzero on bulk endpoint");

   iso_nodata_zero_a: assert property (@(posedge clk_sys) // [RL4]
      disable iff (reset)
      (host_mode && is_iso && rd && sel_csr)
      |=> !wb_dat_o[urx_pkg::BIT_ERR])
      else $error("no-data bit read nonzero on iso endpoint");

   drop_sets_err_a: assert property (@(posedge clk_sys) // [RL1]
      disable iff (reset)
      (!host_mode && evt.pkt_dropped) |=> err_flag)
      else $error("dropped packet did not set overrun");

   nodata_three_a: assert property (@(posedge clk_sys) // [RL3]
      disable iff (reset)
      (host_mode && !is_iso && set_err && mask[urx_pkg::IRQ_ERR])
      |=> (err_flag && irq))
      else $error("third empty attempt did not flag and interrupt");

   err_hold_a: assert property (@(posedge clk_sys) // [RL8]
      disable iff (reset)
      (err_flag && !clr_err) |=> err_flag)
      else $error("error flag cleared without software write");

   full_read_a: assert property (@(posedge clk_sys) // [RL5] [RL15]
      disable iff (reset)
      (rd && sel_csr) |=> wb_dat_o[urx_pkg::BIT_FULL] == $past(fifo_no_room))
      else $error("fifo full bit does not follow fifo state");

   rdy_irq_a: assert property (@(posedge clk_sys) // [RL6]
      disable iff (reset)
      (evt.pkt_done && mask[urx_pkg::IRQ_RDY]) |=> (rdy_flag && irq))
      else $error("received packet did not flag and interrupt");

   rdy_clear_a: assert property (@(posedge clk_sys) // [RL7]
      disable iff (reset)
      (clr_rdy && !set_rdy) |=> !rdy_flag)
      else $error("writing zero did not clear packet waiting");

   payload_size_a: assert property (@(posedge clk_sys) // [RL9]
      disable iff (reset)
      1'b1 |=> cfg.payload_bytes == $past(limit) * ($past(repeat_count) + 1))
      else $error("payload size not limit times count plus one");

   limit_write_a: assert property (@(posedge clk_sys) // [RL13]
      disable iff (reset)
      (wr && sel_csr && wb_sel_i[1:0] == 2'h3)
      |=> limit == $past(wb_dat_i[urx_pkg::MAXP_HI:0]))
      else $error("payload limit write lost");

   // irq is registered, so it tracks status only while the mask holds
   irq_level_a: assert property (@(posedge clk_sys) // [RL3] [RL6]
      disable iff (reset)
      $stable(mask) |-> irq == |(istat & mask))
      else $error("interrupt does not follow unmasked status");

   rdy_set_wins_a: assert property (@(posedge clk_sys) // [RL6]
      disable iff (reset)
      (set_rdy && clr_rdy) |=> rdy_flag)
      else $error("packet waiting lost to a same-cycle clear");

   err_set_wins_a: assert property (@(posedge clk_sys) // [RL1] [RL3]
      disable iff (reset)
      (set_err && clr_err) |=> err_flag)
      else $error("error flag lost to a same-cycle clear");

   ack_pulse_a: assert property (@(posedge clk_sys)
      disable iff (reset)
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held for more than one cycle");
endmodule : urx_ctrl

//--- urx_rx_model.sv
/*
 receive engine stand-in: fifo occupancy and one-cycle event pulses.
 assumes one-cycle command strobes from the bench on clk_sys.
*/
`timescale 1ns/1ps
module urx_rx_model
#(
   parameter int DEPTH = 2
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] cmd,
   output urx_pkg::urx_evt_t evt,
   output logic fifo_no_room
);
   // ----------------------------------------
   // fifo level and events
   // ----------------------------------------
   int count;
   logic take;
   assign fifo_no_room = (count == DEPTH);
   // a load stands for a packet that is a whole multiple of the limit
   assign take = cmd[0] && !fifo_no_room;
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         count <= 0;
         evt <= '0;
      end
      else
      begin
         evt.pkt_done <= take;
         evt.pkt_dropped <= cmd[0] && fifo_no_room;
         evt.rx_attempt_empty <= cmd[2];
         evt.rx_attempt_data <= cmd[3];
         // a slot frees the cycle after unload
         count <= count + int'(take) - int'(cmd[1] && count > 0);
      end
   end
endmodule : urx_rx_model

//--- urx_ctrl_tb.sv
/*
 self-checking bench for urx_ctrl driven over classic wishbone.
 assumes the package, design and receive model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e, m) \
   begin checked++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %0t %s", $time, m); end end
module urx_ctrl_tb;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic host_mode = 1'b0;
   urx_pkg::urx_xfer_t xfer_type = urx_pkg::URX_XFER_ISO;
   logic fifo_no_room;
   urx_pkg::urx_evt_t evt;
   urx_pkg::urx_cfg_t cfg;
   logic irq;
   logic [3:0] cmd = 4'h0;
   logic [31:0] rd;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   always #2.5 clk_sys = ~clk_sys;
   urx_ctrl u_urx_ctrl (.clk_sys(clk_sys), .reset(reset),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_mode(host_mode),
      .xfer_type(xfer_type), .fifo_no_room(fifo_no_room), .evt(evt),
      .cfg(cfg), .irq(irq));
   urx_rx_model u_urx_rx_model (.clk_sys(clk_sys), .reset(reset),
      .cmd(cmd), .evt(evt), .fifo_no_room(fifo_no_room));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task automatic wb(input logic we, input logic [3:0] adr,
      input logic [3:0] sel, input logic [31:0] dat);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      // only the watchdog ends a wait that never sees ack
      do
      begin
         @(posedge clk_sys);
      end
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb
   task automatic rchk(input logic [3:0] adr, input logic [31:0] e);
      wb(1'b0, adr, 4'hF, 32'h0);
      `CHK(rd, e, "read value")
   endtask : rchk
   task automatic pulse(input logic [3:0] c);
      @(posedge clk_sys);
      cmd <= c;
      @(posedge clk_sys);
      cmd <= 4'h0;
      repeat (2) @(posedge clk_sys);
   endtask : pulse
   task automatic mode(input logic h, input urx_pkg::urx_xfer_t t);
      @(posedge clk_sys);
      host_mode <= h;
      xfer_type <= t;
   endtask : mode
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      rchk(urx_pkg::OFF_CSR, 32'h0);
      rchk(urx_pkg::OFF_IRQ_MASK, 32'h0);
      wb(1'b1, 4'h2, 4'hF, 32'hFFFFFFFF);
      rchk(4'h2, 32'h0);
      `CHK(irq, 1'b0, "irq at reset")
      $display("test reset done");
   endtask : t_reset
   task automatic t_payload();
      wb(1'b1, urx_pkg::OFF_CSR, 4'hF, 32'h0000FFFE);
      rchk(urx_pkg::OFF_CSR, 32'h0000FFFE);
      `CHK(cfg.payload_bytes, 17'h0FFC0, "bulk split")
      wb(1'b1, urx_pkg::OFF_CSR, 4'hF, 32'h00001400);
      wb(1'b1, urx_pkg::OFF_CSR, 4'h1, 32'h000000AA);
      rchk(urx_pkg::OFF_CSR, 32'h000014AA);
      `CHK(cfg.payload_bytes, 17'h00DFE, "payload")
      `CHK(cfg.limit, 11'h4AA, "limit")
      `CHK(cfg.repeat_count, 5'h02, "repeat count")
      wb(1'b1, urx_pkg::OFF_MODE, 4'hF, 32'h1);
      rchk(urx_pkg::OFF_MODE, 32'h1);
      $display("test payload done");
   endtask : t_payload
   task automatic t_ready();
      wb(1'b1, urx_pkg::OFF_IRQ_MASK, 4'hF, 32'h1);
      pulse(4'h1);
      `CHK(irq, 1'b1, "ready irq")
      rchk(urx_pkg::OFF_CSR, 32'h000114AA);
      pulse(4'h1);
      rchk(urx_pkg::OFF_CSR, 32'h000314AA);
      pulse(4'h2);
      rchk(urx_pkg::OFF_CSR, 32'h000114AA);
      wb(1'b1, urx_pkg::OFF_CSR, 4'hF, 32'h000014AA);
      rchk(urx_pkg::OFF_CSR, 32'h000014AA);
      rchk(urx_pkg::OFF_IRQ_STAT, 32'h1);
      rchk(urx_pkg::OFF_IRQ_STAT, 32'h0);
      `CHK(irq, 1'b0, "irq after clear")
      $display("test ready done");
   endtask : t_ready
   task automatic t_overrun();
      pulse(4'h1);
      pulse(4'h1);
      rchk(urx_pkg::OFF_CSR, 32'h000714AA);
      mode(1'b0, urx_pkg::URX_XFER_BULK);
      rchk(urx_pkg::OFF_CSR, 32'h000314AA);
      mode(1'b0, urx_pkg::URX_XFER_ISO);
      rchk(urx_pkg::OFF_CSR, 32'h000714AA);
      wb(1'b1, urx_pkg::OFF_CSR, 4'hF, 32'h000014AA);
      rchk(urx_pkg::OFF_CSR, 32'h000214AA);
      pulse(4'h2);
      pulse(4'h2);
      rchk(urx_pkg::OFF_IRQ_STAT, 32'h1);
      $display("test overrun done");
   endtask : t_overrun
   task automatic t_nodata();
      mode(1'b1, urx_pkg::URX_XFER_BULK);
      wb(1'b1, urx_pkg::OFF_IRQ_MASK, 4'hF, 32'h2);
      pulse(4'h4);
      pulse(4'h4);
      pulse(4'h8);
      pulse(4'h4);
      pulse(4'h4);
      rchk(urx_pkg::OFF_CSR, 32'h000014AA);
      `CHK(irq, 1'b0, "early error irq")
      pulse(4'h4);
      rchk(urx_pkg::OFF_CSR, 32'h000414AA);
      `CHK(irq, 1'b1, "error irq")
      mode(1'b1, urx_pkg::URX_XFER_ISO);
      rchk(urx_pkg::OFF_CSR, 32'h000014AA);
      mode(1'b1, urx_pkg::URX_XFER_INT);
      rchk(urx_pkg::OFF_CSR, 32'h000414AA);
      wb(1'b1, urx_pkg::OFF_CSR, 4'hF, 32'h000014AA);
      rchk(urx_pkg::OFF_IRQ_STAT, 32'h2);
      rchk(urx_pkg::OFF_CSR, 32'h000014AA);
      `CHK(irq, 1'b0, "irq cleared")
      $display("test nodata done");
   endtask : t_nodata
   // ----------------------------------------
   // run and watchdog
   // ----------------------------------------
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_total++;
         test_done();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_payload();
      t_ready();
      t_overrun();
      t_nodata();
      test_done();
   end
endmodule : urx_ctrl_tb
